// [sflash_pkg.sv]
// Shared types and constants for the serial flash command front end
package sflash_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Frame layout: opcode byte then three address bytes
    localparam logic [4:0] HDR_LAST = 5'h1f;
    localparam logic [2:0] BYTE_LAST = 3'h7;
    localparam logic [2:0] TX_FIRST = 3'h7;

    // Opcode values
    localparam logic [7:0] OPC_READ = 8'h40;
    localparam logic [7:0] OPC_PAGE_PROG = 8'h10;
    localparam logic [7:0] OPC_ERASE_PAGE = 8'h20;
    localparam logic [7:0] OPC_ERASE_BLOCK = 8'h21;
    localparam logic [7:0] OPC_ERASE_SECTOR = 8'h22;
    localparam logic [7:0] OPC_ERASE_CHIP = 8'h23;
    localparam logic [7:0] OPC_PROT_ENABLE = 8'h30;
    localparam logic [7:0] OPC_LOCKDOWN = 8'h31;
    localparam logic [7:0] OPC_PROT_WRITE = 8'h32;

    // Reset levels of the pins and of the output enable
    localparam logic CS_IDLE = 1'b1;
    localparam logic OE_N_OFF = 1'b1;
    localparam logic [4:0] PINS_RESET = 5'b01011;

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {ITEM_CMD, ITEM_DATA, ITEM_END} item_kind_e;

    typedef enum logic [3:0] {
        CLS_OTHER, CLS_READ, CLS_PROGRAM, CLS_ERASE_PAGE, CLS_ERASE_BLOCK,
        CLS_ERASE_SECTOR, CLS_ERASE_CHIP, CLS_PROT_ENABLE, CLS_LOCKDOWN,
        CLS_PROT_WRITE
    } op_class_e;

    typedef struct packed {
        item_kind_e kind;
        op_class_e cls;
        logic [7:0] opcode;
        logic [11:0] main_row_index;
        logic [8:0] main_byte_offset;
        logic [8:0] buffer_offset_nine;
        logic [7:0] buffer_offset_eight;
        logic [19:0] linear_main_address;
        logic [7:0] data;
    } item_s;

    // Synchronised pins, order fixed by PINS_RESET
    typedef struct packed {
        logic sck;
        logic cs_n;
        logic si;
        logic wp_n;
        logic rst_n;
    } pins_s;

    typedef enum logic [2:0] {ST_IDLE, ST_HDR, ST_RX, ST_TX, ST_DROP}
        fe_state_e;

    typedef struct packed {
        fe_state_e st;
        logic sck_q;
        logic cs_q;
        logic [4:0] cnt;
        logic [31:0] sh;
        logic [7:0] tx;
        logic [2:0] tx_cnt;
        logic [7:0] pre;
        logic pre_ok;
        logic so;
        logic so_oe_n;
        item_s push;
        logic push_v;
        logic ovr;
        logic unr;
        logic stby;
    } fe_st_s;

endpackage

// [pin_sync.sv]
// Two-flop synchroniser for the pins of the serial link
`timescale 1ns/1ps
module pin_sync (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire sflash_pkg::pins_s pins_i,
    output sflash_pkg::pins_s pins_o
);

    typedef struct packed {
        sflash_pkg::pins_s meta;
        sflash_pkg::pins_s stable;
    } sync_st_s;

    sync_st_s s_r;
    sync_st_s s_nxt;

    ////////////////////////////////////////////////////////////////////////
    // First stage feeds only the second stage
    always_comb begin
        s_nxt = s_r;
        s_nxt.meta = pins_i;
        s_nxt.stable = s_r.meta;
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_r.meta <= sflash_pkg::pins_s'(sflash_pkg::PINS_RESET);
            s_r.stable <= sflash_pkg::pins_s'(sflash_pkg::PINS_RESET);
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pins_o = s_r.stable;

endmodule

// [item_buf2.sv]
// Two-entry buffer between the link decoder and the array logic
`timescale 1ns/1ps
module item_buf2 (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic in_valid_i,
    input wire sflash_pkg::item_s in_item_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output sflash_pkg::item_s out_item_o,
    input wire logic out_ready_i
);

    typedef struct packed {
        sflash_pkg::item_s [1:0] mem;
        logic [1:0] cnt;
        logic rd;
    } buf_st_s;

    buf_st_s s_r;
    buf_st_s s_nxt;
    logic push;
    logic pop;
    logic wr;

    ////////////////////////////////////////////////////////////////////////
    assign in_ready_o = (s_r.cnt != 2'h2);
    assign out_valid_o = (s_r.cnt != 2'h0);
    assign out_item_o = s_r.mem[s_r.rd];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign wr = s_r.rd ^ s_r.cnt[0];

    always_comb begin
        s_nxt = s_r;
        if (push) begin
            s_nxt.mem[wr] = in_item_i;
        end
        if (pop) begin
            s_nxt.rd = ~s_r.rd;
        end
        if (push && !pop) begin
            s_nxt.cnt = s_r.cnt + 2'h1;
        end else if (pop && !push) begin
            s_nxt.cnt = s_r.cnt - 2'h1;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule

// [sflash_front_end.sv]
// Serial flash command front end: link decoder, protection gate, streams
`timescale 1ns/1ps
module sflash_front_end (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    input wire logic wp_n_i,
    input wire logic dev_rst_n_i,
    output logic so_o,
    output logic so_oe_n_o,
    input wire logic page_bin_i,
    input wire logic busy_i,
    output logic cmd_valid_o,
    output sflash_pkg::item_s cmd_o,
    input wire logic cmd_ready_i,
    input wire logic rd_valid_i,
    input wire logic [7:0] rd_data_i,
    output logic rd_ready_o,
    output logic overrun_o,
    output logic underrun_o,
    output logic standby_o,
    output logic abort_o
);

    sflash_pkg::fe_st_s s_r;
    sflash_pkg::fe_st_s s_nxt;
    sflash_pkg::pins_s raw;
    sflash_pkg::pins_s p;
    logic in_ready;
    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    logic cs_rise;
    logic [31:0] hdr;
    sflash_pkg::op_class_e cls;
    logic rd_take;

    ////////////////////////////////////////////////////////////////////////
    // Opcode classes; erase granularities each have their own class
    function automatic sflash_pkg::op_class_e classify(
        input logic [7:0] op
    );
        sflash_pkg::op_class_e c;
        c = sflash_pkg::CLS_OTHER;
        unique case (op)
            sflash_pkg::OPC_READ: c = sflash_pkg::CLS_READ;
            sflash_pkg::OPC_PAGE_PROG: c = sflash_pkg::CLS_PROGRAM;
            sflash_pkg::OPC_ERASE_PAGE: c = sflash_pkg::CLS_ERASE_PAGE;
            sflash_pkg::OPC_ERASE_BLOCK: c = sflash_pkg::CLS_ERASE_BLOCK;
            sflash_pkg::OPC_ERASE_SECTOR: c = sflash_pkg::CLS_ERASE_SECTOR;
            sflash_pkg::OPC_ERASE_CHIP: c = sflash_pkg::CLS_ERASE_CHIP;
            sflash_pkg::OPC_PROT_ENABLE: c = sflash_pkg::CLS_PROT_ENABLE;
            sflash_pkg::OPC_LOCKDOWN: c = sflash_pkg::CLS_LOCKDOWN;
            sflash_pkg::OPC_PROT_WRITE: c = sflash_pkg::CLS_PROT_WRITE;
            default: c = sflash_pkg::CLS_OTHER;
        endcase
        return c;
    endfunction

    // Commands that hardware protection refuses; enable and lockdown pass
    function automatic logic wp_blocked(input sflash_pkg::op_class_e c);
        logic b;
        b = 1'b0;
        unique case (c)
            sflash_pkg::CLS_PROGRAM,
            sflash_pkg::CLS_ERASE_PAGE,
            sflash_pkg::CLS_ERASE_BLOCK,
            sflash_pkg::CLS_ERASE_SECTOR,
            sflash_pkg::CLS_ERASE_CHIP: b = 1'b1;
            sflash_pkg::CLS_PROT_WRITE: b = 1'b1;
            default: b = 1'b0;
        endcase
        return b;
    endfunction

    // Splits the 24 address bits for the current page-size mode
    function automatic sflash_pkg::item_s make_cmd(
        input logic [7:0] op,
        input sflash_pkg::op_class_e c,
        input logic [23:0] a,
        input logic bin
    );
        sflash_pkg::item_s it;
        it = '0;
        it.kind = sflash_pkg::ITEM_CMD;
        it.cls = c;
        it.opcode = op;
        if (bin) begin
            it.linear_main_address = a[19:0];
            it.main_row_index = a[19:8];
            it.main_byte_offset = {1'b0, a[7:0]};
            it.buffer_offset_eight = a[7:0];
        end else begin
            it.main_row_index = a[20:9];
            it.main_byte_offset = a[8:0];
            it.buffer_offset_nine = a[8:0];
        end
        return it;
    endfunction

    // Frame end marks and data bytes carry no address fields
    function automatic sflash_pkg::item_s make_mark(
        input sflash_pkg::item_kind_e k,
        input logic [7:0] d
    );
        sflash_pkg::item_s it;
        it = '0;
        it.kind = k;
        it.data = d;
        return it;
    endfunction

    // Counters and prefetch restart at every frame and at the reset pin
    function automatic sflash_pkg::fe_st_s frame_clear(
        input sflash_pkg::fe_st_s s
    );
        sflash_pkg::fe_st_s r;
        r = s;
        r.cnt = 5'h00;
        r.tx_cnt = 3'h0;
        r.pre_ok = 1'b0;
        return r;
    endfunction

    // One output step: top bit to the pin, the rest moves up
    function automatic logic [8:0] shift_tx(input logic [7:0] v);
        return {v[7], v[6:0], 1'b0};
    endfunction

    // Edge of a synchronised pin against its copy from the cycle before
    function automatic logic edge_of(
        input logic now,
        input logic was,
        input logic rising
    );
        return rising ? (now && !was) : (!now && was);
    endfunction

    // Reads turn the link around; everything else keeps shifting in
    function automatic sflash_pkg::fe_state_e after_hdr(
        input sflash_pkg::op_class_e c
    );
        return (c == sflash_pkg::CLS_READ) ?
               sflash_pkg::ST_TX : sflash_pkg::ST_RX;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; write-protect resets high, so a floating pin
    // that the pad pull-up holds high leaves protection off
    assign raw.sck = sck_i;
    assign raw.cs_n = cs_n_i;
    assign raw.si = si_i;
    assign raw.wp_n = wp_n_i;
    assign raw.rst_n = dev_rst_n_i;

    pin_sync u_sync (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .pins_i(raw),
        .pins_o(p)
    );

    item_buf2 u_buf (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .in_valid_i(s_r.push_v),
        .in_item_i(s_r.push),
        .in_ready_o(in_ready),
        .out_valid_o(cmd_valid_o),
        .out_item_o(cmd_o),
        .out_ready_i(cmd_ready_i)
    );

    ////////////////////////////////////////////////////////////////////////
    // Edges of the synchronised link clock and chip select
    assign sck_rise = edge_of(p.sck, s_r.sck_q, 1'b1);
    assign sck_fall = edge_of(p.sck, s_r.sck_q, 1'b0);
    assign cs_fall = edge_of(p.cs_n, s_r.cs_q, 1'b0);
    assign cs_rise = edge_of(p.cs_n, s_r.cs_q, 1'b1);
    assign hdr = {s_r.sh[30:0], p.si};
    assign cls = classify(hdr[31:24]);

    // Prefetch one byte ahead so the first falling edge has data
    assign rd_ready_o = (s_r.st == sflash_pkg::ST_TX) && !s_r.pre_ok;
    assign rd_take = rd_valid_i && rd_ready_o;

    ////////////////////////////////////////////////////////////////////////
    // Frame control
    always_comb begin
        logic [7:0] b;
        b = 8'h00;
        s_nxt = s_r;
        s_nxt.sck_q = p.sck;
        s_nxt.cs_q = p.cs_n;
        s_nxt.push_v = 1'b0;
        // Standby waits for the array, so a self-timed job is never cut
        s_nxt.stby = p.cs_n && !busy_i && p.rst_n;
        if (!p.rst_n) begin
            // Hold idle for as long as the reset pin stays low
            s_nxt.st = sflash_pkg::ST_IDLE;
            s_nxt = frame_clear(s_nxt);
            s_nxt.so = 1'b0;
            s_nxt.so_oe_n = sflash_pkg::OE_N_OFF;
        end else if (p.cs_n) begin
            // Deselected: close the frame, float the output
            if (cs_rise && (s_r.st != sflash_pkg::ST_IDLE) &&
                (s_r.st != sflash_pkg::ST_DROP)) begin
                s_nxt.push = make_mark(sflash_pkg::ITEM_END, 8'h00);
                s_nxt.push_v = 1'b1;
            end
            s_nxt.st = sflash_pkg::ST_IDLE;
            s_nxt.so = 1'b0;
            s_nxt.so_oe_n = sflash_pkg::OE_N_OFF;
        end else if (cs_fall) begin
            s_nxt.st = sflash_pkg::ST_HDR;
            s_nxt = frame_clear(s_nxt);
            s_nxt.ovr = 1'b0;
            s_nxt.unr = 1'b0;
            s_nxt.so_oe_n = 1'b0;
        end else if (sck_rise && ((s_r.st == sflash_pkg::ST_HDR) ||
                     (s_r.st == sflash_pkg::ST_RX))) begin
            s_nxt.sh = hdr;
            s_nxt.cnt = s_r.cnt + 5'h01;
            if (s_r.st == sflash_pkg::ST_HDR) begin
                if (s_r.cnt == sflash_pkg::HDR_LAST) begin
                    s_nxt.cnt = 5'h00;
                    if (!p.wp_n && wp_blocked(cls)) begin
                        // Nothing reaches the array for this frame
                        s_nxt.st = sflash_pkg::ST_DROP;
                    end else begin
                        s_nxt.push = make_cmd(hdr[31:24], cls,
                                              hdr[23:0], page_bin_i);
                        s_nxt.push_v = 1'b1;
                        s_nxt.st = after_hdr(cls);
                    end
                end
            end else if (s_r.cnt[2:0] == sflash_pkg::BYTE_LAST) begin
                s_nxt.push = make_mark(sflash_pkg::ITEM_DATA,
                                       hdr[7:0]);
                s_nxt.push_v = 1'b1;
            end
        end else if (sck_fall && (s_r.st == sflash_pkg::ST_TX)) begin
            if (s_r.tx_cnt == 3'h0) begin
                // Late read data sends zeros rather than stalling the host
                b = s_r.pre_ok ? s_r.pre : 8'h00;
                if (!s_r.pre_ok) begin
                    s_nxt.unr = 1'b1;
                end
                {s_nxt.so, s_nxt.tx} = shift_tx(b);
                s_nxt.tx_cnt = sflash_pkg::TX_FIRST;
                s_nxt.pre_ok = 1'b0;
            end else begin
                {s_nxt.so, s_nxt.tx} = shift_tx(s_r.tx);
                s_nxt.tx_cnt = s_r.tx_cnt - 3'h1;
            end
        end
        // The link cannot be stalled, so a refused push is flagged
        if (s_r.push_v && !in_ready) begin
            s_nxt.ovr = 1'b1;
        end
        if (rd_take) begin
            s_nxt.pre = rd_data_i;
            s_nxt.pre_ok = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; the reset pin is handled as data, not as a reset
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_r <= '0;
            s_r.cs_q <= sflash_pkg::CS_IDLE;
            s_r.so_oe_n <= sflash_pkg::OE_N_OFF;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign so_o = s_r.so;
    assign so_oe_n_o = s_r.so_oe_n;
    assign overrun_o = s_r.ovr;
    assign underrun_o = s_r.unr;
    assign standby_o = s_r.stby;
    assign abort_o = ~p.rst_n;

endmodule

// [sflash_front_end_monitor.sv]
// Assertion checker for the serial flash command front end
`timescale 1ns/1ps
module sflash_front_end_monitor (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic wp_n_i,
    input wire logic dev_rst_n_i,
    input wire logic so_o,
    input wire logic so_oe_n_o,
    input wire logic busy_i,
    input wire logic cmd_valid_o,
    input wire sflash_pkg::item_s cmd_o,
    input wire logic cmd_ready_i,
    input wire logic standby_o,
    input wire logic abort_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    ////////////////////////////////////////
    // Pins pass two sync flops, so every window allows that lag
    logic allowed;
    assign allowed = cmd_o.cls inside {sflash_pkg::CLS_OTHER,
        sflash_pkg::CLS_READ, sflash_pkg::CLS_PROT_ENABLE,
        sflash_pkg::CLS_LOCKDOWN};
    sequence s_rst_held;
        !dev_rst_n_i [*4];
    endsequence
    sequence s_quiet;
        (cs_n_i && !busy_i && dev_rst_n_i) [*5];
    endsequence
    chk_so_float: assert property (
        cs_n_i [*5] |-> so_oe_n_o)
        else $error("output driven while deselected");
    chk_so_edge: assert property (
        $changed(so_o) && !so_oe_n_o && !$past(so_oe_n_o)
        |-> !$past(sck_i, 2))
        else $error("output bit moved away from a clock fall");
    chk_abort_lvl: assert property (
        s_rst_held |-> abort_o)
        else $error("abort missing while reset pin low");
    chk_abort_float: assert property (
        s_rst_held |=> so_oe_n_o)
        else $error("output driven during reset pin");
    chk_no_cmd_rst: assert property (
        (!dev_rst_n_i) [*7] |=> !$rose(cmd_valid_o))
        else $error("command taken during reset pin");
    chk_abort_clear: assert property (
        dev_rst_n_i [*4] |-> !abort_o)
        else $error("abort stays after reset pin high");
    chk_standby_busy: assert property (
        busy_i |=> !standby_o)
        else $error("standby while array busy");
    chk_standby_idle: assert property (
        s_quiet |-> standby_o)
        else $error("no standby after frame end");
    chk_wp_gate: assert property (
        $rose(cmd_valid_o) && cmd_o.kind == sflash_pkg::ITEM_CMD &&
        !$past(wp_n_i, 3) && !$past(wp_n_i, 4) |-> allowed)
        else $error("protected command passed");
    chk_item_hold: assert property (
        cmd_valid_o && !cmd_ready_i |=> cmd_valid_o && $stable(cmd_o))
        else $error("stalled item changed");
endmodule

// [flash_host_model.sv]
// Host controller model driving the serial link of the front end
`timescale 1ns/1ps
module flash_host_model (
    input wire logic core_clk_i,
    input wire logic so_i,
    output logic sck_o,
    output logic cs_n_o,
    output logic si_o
);
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
    end
    ////////////////////////////////////////
    // Half of the 160 ns link period; clock rests low between frames
    task automatic wait_half();
        repeat (4) @(posedge core_clk_i);
    endtask
    task automatic begin_frame();
        @(posedge core_clk_i);
        cs_n_o <= 1'b0;
        wait_half();
    endtask
    task automatic xfer_byte(input logic [7:0] b, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            si_o <= b[i];
            wait_half();
            r[i] = so_i;
            sck_o <= 1'b1;
            wait_half();
            sck_o <= 1'b0;
        end
    endtask
    task automatic end_frame();
        wait_half();
        cs_n_o <= 1'b1;
        // Released line shows a changed level, never the last bit
        si_o <= ~si_o;
        repeat (3) wait_half();
    endtask
endmodule

// [sflash_front_end_tb.sv]
// Self-checking testbench for the serial flash command front end
`timescale 1ns/1ps
module sflash_front_end_tb;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic wp_en = 1'b0;
    logic wp_v = 1'b1;
    logic dev_rst_n = 1'b1;
    logic page_bin = 1'b0;
    logic busy = 1'b0;
    logic cmd_rdy = 1'b1;
    logic rd_valid = 1'b1;
    logic [7:0] rd_data = 8'h00;
    logic rd_ready, so, so_oe_n, cmd_valid, ovr, stby, abrt, sck, cs_n, si;
    logic unr;
    tri1 wp_n;
    sflash_pkg::item_s cmd;
    sflash_pkg::item_s q[$];
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;
    // Open pin floats to the pull-up, as an unconnected board would
    assign wp_n = wp_en ? wp_v : 1'bz;
    always #10 clk = ~clk;
    sflash_front_end dut (
        .core_clk_i(clk),
        .resetn_i(resetn),
        .sck_i(sck),
        .cs_n_i(cs_n),
        .si_i(si),
        .wp_n_i(wp_n),
        .dev_rst_n_i(dev_rst_n),
        .so_o(so),
        .so_oe_n_o(so_oe_n),
        .page_bin_i(page_bin),
        .busy_i(busy),
        .cmd_valid_o(cmd_valid),
        .cmd_o(cmd),
        .cmd_ready_i(cmd_rdy),
        .rd_valid_i(rd_valid),
        .rd_data_i(rd_data),
        .rd_ready_o(rd_ready),
        .overrun_o(ovr),
        .underrun_o(unr),
        .standby_o(stby),
        .abort_o(abrt)
    );
    flash_host_model host (
        .core_clk_i(clk),
        .so_i(so),
        .sck_o(sck),
        .cs_n_o(cs_n),
        .si_o(si)
    );
    ////////////////////////////////////////
    always @(posedge clk) begin
        cycles++;
        if (cmd_valid && cmd_rdy) q.push_back(cmd);
        if (rd_valid && rd_ready) rd_data <= rd_data + 8'h11;
        if (cycles == 40000) begin
            n_errors++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic frame(input logic [7:0] op, input logic [23:0] a,
                         input int n, output logic [15:0] rb);
        logic [7:0] r;
        host.begin_frame();
        host.xfer_byte(op, r);
        for (int k = 2; k >= 0; k--) host.xfer_byte(a[k*8 +: 8], r);
        rb = 16'h0000;
        for (int k = 0; k < n; k++) begin
            host.xfer_byte(8'h81 + 8'(k), r);
            rb = {rb[7:0], r};
        end
        host.end_frame();
    endtask
    task automatic chk_cmd(input sflash_pkg::item_s it,
                           input logic [7:0] op, input logic [23:0] a);
        chk(it.kind, sflash_pkg::ITEM_CMD);
        chk(it.opcode, op);
        if (page_bin) begin
            chk(it.linear_main_address, a[19:0]);
            chk(it.main_row_index, a[19:8]);
            chk(it.buffer_offset_eight, a[7:0]);
        end else begin
            chk(it.main_row_index, a[20:9]);
            chk(it.main_byte_offset, a[8:0]);
            chk(it.buffer_offset_nine, a[8:0]);
        end
    endtask
    task automatic t_read();
        logic [15:0] rb;
        rd_data <= 8'ha5;
        frame(sflash_pkg::OPC_READ, 24'h1abcde, 2, rb);
        chk(rb, 16'ha5b6);
        chk(q.size(), 2);
        chk_cmd(q[0], sflash_pkg::OPC_READ, 24'h1abcde);
        chk(q[1].kind, sflash_pkg::ITEM_END);
        chk(so_oe_n, 1'b1);
        chk(unr, 1'b0);
        q.delete();
        rd_valid <= 1'b0;
        frame(sflash_pkg::OPC_READ, 24'h000000, 1, rb);
        chk(rb, 16'h0000);
        chk(unr, 1'b1);
        chk(q.size(), 2);
        rd_valid <= 1'b1;
        q.delete();
    endtask
    task automatic t_wp();
        logic [7:0] ops [8] = '{8'h10, 8'h20, 8'h21, 8'h22, 8'h23, 8'h30,
                                8'h31, 8'h32};
        logic [15:0] rb;
        logic ok;
        page_bin <= 1'b1;
        for (int w = 0; w < 2; w++) begin
            for (int i = 0; i < 8; i++) begin
                wp_en <= w[0];
                wp_v <= 1'b0;
                frame(ops[i], 24'h0fedcb, 1, rb);
                ok = (w == 0) || (i == 5) || (i == 6);
                chk(q.size(), ok ? 3 : 0);
                if (ok) begin
                    chk_cmd(q[0], ops[i], 24'h0fedcb);
                    chk(q[0].cls, i + 2);
                    chk(q[1].data, 8'h81);
                end
                q.delete();
            end
        end
        wp_en <= 1'b0;
    endtask
    task automatic t_stall();
        logic [15:0] rb;
        cmd_rdy <= 1'b0;
        frame(sflash_pkg::OPC_PAGE_PROG, 24'h000100, 3, rb);
        chk(ovr, 1'b1);
        chk(q.size(), 0);
        cmd_rdy <= 1'b1;
        repeat (4) @(posedge clk);
        chk(q.size(), 2);
        chk(q[1].data, 8'h81);
        chk(cmd_valid, 1'b0);
        q.delete();
    endtask
    task automatic t_reset();
        logic [7:0] r;
        logic [15:0] rb;
        host.begin_frame();
        host.xfer_byte(sflash_pkg::OPC_PAGE_PROG, r);
        dev_rst_n <= 1'b0;
        host.xfer_byte(8'h00, r);
        chk(abrt, 1'b1);
        chk(so_oe_n, 1'b1);
        host.end_frame();
        q.delete();
        frame(sflash_pkg::OPC_ERASE_CHIP, 24'h000000, 0, rb);
        chk(q.size(), 0);
        dev_rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        frame(sflash_pkg::OPC_ERASE_CHIP, 24'h000000, 0, rb);
        chk(abrt, 1'b0);
        chk(q.size(), 2);
        chk(ovr, 1'b0);
        q.delete();
    endtask
    task automatic t_busy();
        busy <= 1'b1;
        repeat (8) @(posedge clk);
        chk(stby, 1'b0);
        busy <= 1'b0;
        repeat (8) @(posedge clk);
        chk(stby, 1'b1);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        t_read();
        t_wp();
        t_stall();
        t_reset();
        t_busy();
        end_sim();
    end
endmodule
bind sflash_front_end sflash_front_end_monitor mon (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .sck_i(sck_i),
    .cs_n_i(cs_n_i),
    .wp_n_i(wp_n_i),
    .dev_rst_n_i(dev_rst_n_i),
    .so_o(so_o),
    .so_oe_n_o(so_oe_n_o),
    .busy_i(busy_i),
    .cmd_valid_o(cmd_valid_o),
    .cmd_o(cmd_o),
    .cmd_ready_i(cmd_ready_i),
    .standby_o(standby_o),
    .abort_o(abort_o)
);
